// File: pdsu_defines.svh
// constants for the processor-dependent space unit
//
// Functional notes
// - decode 21-bit byte address from low bits
// - 000000-15FFFF go external with fast timing
// - 180000-1FFFFF go external with slow timing
// - 32-bit seconds counter at 160000 counts seconds
// - seconds counter survives reset, changes by writes and once per second
// - token answers at 160004-160007, read acquires
// - power-up token available, owner zero
// - any token write sets available, owner kept
// - token read returns bit, clears if set
// - owner bits 28-30; acquiring read stores reader
// - read while owned returns owner, zero, unchanged
// - available bit 31, bits 0-27 read zero
// - write-only panel register 160008, payload bits 12-31
// - panel payload shifted out one bit per clock
// - 16000C-17FFFF discard writes, read zero, no error
// - external timing fixed by address, no handshake
// - control-transfer input issues command reset to target
// - viewport bit shows jig-selected sets from the data lines on address pins
// - attached to first adapter system bus side only
`ifndef PDSU_DEFINES_SVH
`define PDSU_DEFINES_SVH
// ===========================================
// address map
`define PDSU_FAST_HI 21'h15FFFF
`define PDSU_SECONDS_ADDR 21'h160000
`define PDSU_TOKEN_LO 21'h160004
`define PDSU_TOKEN_HI 21'h160007
`define PDSU_PANEL_ADDR 21'h160008
`define PDSU_SLOW_LO 21'h180000
// ===========================================
// field positions
`define PDSU_AVAIL_BIT 31
`define PDSU_OWNER_LSB 28
`define PDSU_PANEL_LSB 12
// ===========================================
// timing in ns and cycles at 200 MHz
`define PDSU_CLK_NS 5
`define PDSU_FAST_NS 50
`define PDSU_SLOW_NS 200
`define PDSU_FAST_CYC ((`PDSU_FAST_NS + `PDSU_CLK_NS - 1) / `PDSU_CLK_NS)
`define PDSU_SLOW_CYC ((`PDSU_SLOW_NS + `PDSU_CLK_NS - 1) / `PDSU_CLK_NS)
`define PDSU_SECOND_CYC 200000000
`define PDSU_PANEL_HALF_CYC 10
`endif

// File: pdsu_pkg.sv
// types for the processor-dependent space unit
package pdsu_pkg;
	// ===========================================
	// access sequencer states
	typedef enum logic [1:0] {
		PDSU_IDLE,
		PDSU_EXT,
		PDSU_DONE
	} pdsu_state_t;
endpackage

// File: pdsu_port_model.sv
// external flash, scratch ram and test jig model for the unit's port
`timescale 1ns/1ps
module pdsu_port_model (
	// port pins from the unit
	input wire logic i_mclk,
	input wire logic [20:0] i_addr,
	input wire logic i_valid,
	input wire logic [7:0] i_data,
	input wire logic i_oe_n,
	input wire logic i_we,
	input wire logic i_re,
	// test jig selector
	input wire logic i_vp,
	input wire logic [7:0] i_sel,
	// data lines back to the unit
	output logic [7:0] o_data
);
	// ===========================================
	// storage
	logic [7:0] mem_q [256]; // bytes by low address, enough for the test set
	logic [7:0] last_q = 8'h00; // last value driven
	// latch write data on the strobe; the device never stretches a cycle
	always_ff @(posedge i_mclk) begin
		if (i_valid && i_we && !i_oe_n) begin
			mem_q[i_addr[7:0]] <= i_data;
		end
		last_q <= o_data;
	end
	// released lines show the inverse so a stale value is never mistaken for data
	always_comb begin
		if (i_vp) begin
			o_data = i_sel; // jig selects the viewed set
		end else if (i_valid && i_re) begin
			o_data = mem_q[i_addr[7:0]];
		end else begin
			o_data = ~last_q;
		end
	end
endmodule

// File: pdsu_unit.sv
// processor-dependent space decoder with internal registers and external port
`timescale 1ns/1ps
`include "pdsu_defines.svh"
module pdsu_unit
	import pdsu_pkg::*;
#(
	parameter int unsigned SECOND_CYC = `PDSU_SECOND_CYC,
	parameter int unsigned PANEL_HALF_CYC = `PDSU_PANEL_HALF_CYC
) (
	// clock and reset
	input wire logic i_mclk,
	input wire logic i_reset,
	// request from the first adapter system bus side
	input wire logic i_req,
	input wire logic i_write,
	input wire logic [31:0] i_addr,
	input wire logic [31:0] i_wdata,
	input wire logic [2:0] i_master_id,
	output logic o_ack,
	output logic [31:0] o_rdata,
	// external memory-like port
	output logic [20:0] o_port_addr,
	output logic o_port_addr_valid,
	output logic [7:0] o_port_data,
	output logic o_port_data_oe_n,
	input wire logic [7:0] i_port_data,
	output logic o_port_write_en,
	output logic o_port_output_en,
	// front panel
	output logic o_panel_serial_out,
	output logic o_panel_shift_clock,
	// transfer of control
	input wire logic i_transfer_of_control_input,
	input wire logic [2:0] i_control_transfer_target_id,
	output logic o_cmd_reset_req,
	output logic [2:0] o_cmd_reset_target,
	// test viewport
	input wire logic i_viewport_en,
	output logic [7:0] o_view_select
);
	// ===========================================
	// parameter checks at elaboration
	// the prescaler needs at least two states per second
	if (SECOND_CYC < 2) begin : g_bad_second
		$error("pdsu_unit: second count too small");
	end
	// the half-period counter is only eight bits wide
	if (PANEL_HALF_CYC < 1 || PANEL_HALF_CYC > 256) begin : g_bad_panel
		$error("pdsu_unit: panel half period out of range");
	end

	// ===========================================
	// decode
	logic [20:0] addr21; // byte address in the space
	assign addr21 = i_addr[20:0];
	logic hit_fast;
	logic hit_slow;
	logic hit_secs;
	logic hit_token;
	logic hit_panel;
	assign hit_fast = addr21 <= `PDSU_FAST_HI;
	assign hit_slow = addr21 >= `PDSU_SLOW_LO;
	// word registers decode by word, so every byte lane of them answers
	assign hit_secs = addr21[20:2] == 19'(`PDSU_SECONDS_ADDR >> 2);
	assign hit_token = addr21 >= `PDSU_TOKEN_LO && addr21 <= `PDSU_TOKEN_HI;
	assign hit_panel = addr21[20:2] == 19'(`PDSU_PANEL_ADDR >> 2);

	pdsu_state_t state_q;
	logic [7:0] wait_q; // remaining external strobe cycles
	logic take; // request accepted this cycle
	assign take = i_req && state_q == PDSU_IDLE;
	logic ext_take;
	assign ext_take = take && (hit_fast || hit_slow);
	logic int_take;
	assign int_take = take && !(hit_fast || hit_slow);

	// ===========================================
	// seconds counter: no reset so value persists
	logic [31:0] secs_q;
	logic [31:0] tick_q; // cycles within the current second
	always_ff @(posedge i_mclk) begin
		if (int_take && i_write && hit_secs) begin
			secs_q <= i_wdata;
		end else if (tick_q == SECOND_CYC - 1) begin
			secs_q <= secs_q + 32'h1;
		end
	end
	// prescaler restarts on reset: this loses under a second of phase,
	// but an unreset counter would never leave its unknown power-up state
	always_ff @(posedge i_mclk or posedge i_reset) begin
		if (i_reset) begin
			tick_q <= 32'h0;
		end else if (tick_q >= SECOND_CYC - 1) begin
			tick_q <= 32'h0;
		end else begin
			tick_q <= tick_q + 32'h1;
		end
	end

	// ===========================================
	// ownership token
	logic avail_q;
	logic [2:0] owner_q;
	always_ff @(posedge i_mclk or posedge i_reset) begin
		if (i_reset) begin
			avail_q <= 1'b1;
			owner_q <= 3'h0;
		end else if (int_take && hit_token) begin
			if (i_write) begin
				avail_q <= 1'b1;
			end else if (avail_q) begin
				avail_q <= 1'b0;
				owner_q <= i_master_id;
			end
		end
	end

	// ===========================================
	// panel shifter, msb first
	logic [19:0] pshift_q;
	logic [4:0] pbits_q; // bits left to send
	logic [7:0] phalf_q;
	logic pclk_q;
	logic pout_q;
	always_ff @(posedge i_mclk or posedge i_reset) begin
		if (i_reset) begin
			pshift_q <= 20'h0;
			pbits_q <= 5'h0;
			phalf_q <= 8'h0;
			pclk_q <= 1'b0;
			pout_q <= 1'b0;
		end else if (int_take && i_write && hit_panel) begin
			// a new write restarts any shift in progress
			pshift_q <= i_wdata[31:`PDSU_PANEL_LSB];
			pbits_q <= 5'd20;
			phalf_q <= 8'h0;
			pclk_q <= 1'b0;
		end else if (pbits_q != 5'h0) begin
			if (phalf_q == 8'(PANEL_HALF_CYC - 1)) begin
				phalf_q <= 8'h0;
				if (!pclk_q) begin
					pout_q <= pshift_q[19];
					pclk_q <= 1'b1;
				end else begin
					pclk_q <= 1'b0;
					pshift_q <= {pshift_q[18:0], 1'b0};
					pbits_q <= pbits_q - 5'h1;
				end
			end else begin
				phalf_q <= phalf_q + 8'h1;
			end
		end else begin
			pclk_q <= 1'b0;
		end
	end
	assign o_panel_serial_out = pout_q;
	assign o_panel_shift_clock = pclk_q;

	// ===========================================
	// access sequencer and external port
	logic write_q;
	always_ff @(posedge i_mclk or posedge i_reset) begin
		if (i_reset) begin
			state_q <= PDSU_IDLE;
			wait_q <= 8'h0;
			write_q <= 1'b0;
			o_ack <= 1'b0;
			o_rdata <= 32'h0;
			o_port_addr <= 21'h0;
			o_port_addr_valid <= 1'b0;
			o_port_data <= 8'h0;
			o_port_data_oe_n <= 1'b1;
			o_port_write_en <= 1'b0;
			o_port_output_en <= 1'b0;
		end else begin
			o_ack <= 1'b0;
			unique case (state_q)
				PDSU_IDLE: begin
					if (ext_take) begin
						// timing chosen purely by address
						wait_q <= hit_fast ? 8'(`PDSU_FAST_CYC) : 8'(`PDSU_SLOW_CYC);
						write_q <= i_write;
						o_port_addr <= addr21;
						o_port_addr_valid <= 1'b1;
						o_port_data <= i_wdata[7:0];
						o_port_data_oe_n <= !i_write;
						o_port_write_en <= i_write;
						o_port_output_en <= !i_write;
						state_q <= PDSU_EXT;
					end else if (int_take) begin
						o_ack <= 1'b1;
						state_q <= PDSU_DONE;
						if (i_write || !(hit_secs || hit_token)) begin
							o_rdata <= 32'h0;
						end else if (hit_secs) begin
							o_rdata <= secs_q;
						end else begin
							o_rdata <= {avail_q, owner_q, 28'h0};
						end
					end
				end
				PDSU_EXT: begin
					if (wait_q == 8'h1) begin
						o_rdata <= write_q ? 32'h0 : {24'h0, i_port_data};
						o_ack <= 1'b1;
						o_port_addr_valid <= 1'b0;
						o_port_data_oe_n <= 1'b1;
						o_port_write_en <= 1'b0;
						o_port_output_en <= 1'b0;
						state_q <= PDSU_DONE;
					end
					wait_q <= wait_q - 8'h1;
				end
				PDSU_DONE: begin
					state_q <= PDSU_IDLE;
				end
			endcase
			// viewport overrides address pins with selected data
			if (i_viewport_en) begin
				o_port_addr <= {13'h0, i_port_data};
			end
		end
	end

	// ===========================================
	// transfer of control forwarding, on rising edge
	logic toc_q;
	always_ff @(posedge i_mclk or posedge i_reset) begin
		if (i_reset) begin
			toc_q <= 1'b0;
			o_cmd_reset_req <= 1'b0;
			o_cmd_reset_target <= 3'h0;
			o_view_select <= 8'h0;
		end else begin
			toc_q <= i_transfer_of_control_input;
			o_cmd_reset_req <= i_transfer_of_control_input && !toc_q;
			o_cmd_reset_target <= i_control_transfer_target_id;
			o_view_select <= i_viewport_en ? i_port_data : 8'h0;
		end
	end

	// ===========================================
	// assertions
	property p_token_acquire;
		@(posedge i_mclk) disable iff (i_reset)
		(int_take && hit_token && !i_write && avail_q) |=> (!avail_q && owner_q == $past(i_master_id));
	endproperty
	a_token_acquire: assert property (p_token_acquire) else $error("token acquire wrong");
	property p_token_write;
		@(posedge i_mclk) disable iff (i_reset)
		(int_take && hit_token && i_write) |=> (avail_q && $stable(owner_q));
	endproperty
	a_token_write: assert property (p_token_write) else $error("token write wrong");
	property p_token_owned;
		@(posedge i_mclk) disable iff (i_reset)
		(int_take && hit_token && !i_write && !avail_q) |=> (o_rdata[31] == 1'b0 && $stable(owner_q));
	endproperty
	a_token_owned: assert property (p_token_owned) else $error("owned read wrong");
	property p_unused_zero;
		@(posedge i_mclk) disable iff (i_reset)
		(int_take && !hit_secs && !hit_token) |=> (o_ack && o_rdata == 32'h0);
	endproperty
	a_unused_zero: assert property (p_unused_zero) else $error("unused space not zero");
	property p_fast_time;
		@(posedge i_mclk) disable iff (i_reset)
		(ext_take && hit_fast) |=> o_port_addr_valid [*8] ##1 o_port_addr_valid [*2] ##1 !o_port_addr_valid;
	endproperty
	a_fast_time: assert property (p_fast_time) else $error("fast timing wrong");
	property p_slow_ack;
		@(posedge i_mclk) disable iff (i_reset)
		(ext_take && hit_slow) |=> !o_ack [*8] ##1 (!o_ack [*8]) ##25 o_ack;
	endproperty
	a_slow_ack: assert property (p_slow_ack) else $error("slow ack early or missing");
	property p_panel_idle;
		@(posedge i_mclk) disable iff (i_reset)
		(pbits_q == 5'h0 && !(int_take && i_write && hit_panel)) |=> !o_panel_shift_clock;
	endproperty
	a_panel_idle: assert property (p_panel_idle) else $error("panel clock not idle");
	property p_toc;
		@(posedge i_mclk) disable iff (i_reset)
		$rose(i_transfer_of_control_input) |=> o_cmd_reset_req;
	endproperty
	a_toc: assert property (p_toc) else $error("control transfer not forwarded");
	property p_secs_write;
		@(posedge i_mclk) disable iff (i_reset)
		(int_take && i_write && hit_secs) |=> secs_q == $past(i_wdata);
	endproperty
	a_secs_write: assert property (p_secs_write) else $error("seconds write lost");
	// ===========================================
	// port timing, data path and side-effect checks
	// a fast access answers eleven edges after it is taken
	property p_fast_ack;
		@(posedge i_mclk) disable iff (i_reset)
		(ext_take && hit_fast) |-> ##11 o_ack;
	endproperty
	a_fast_ack: assert property (p_fast_ack) else $error("fast access answer late");
	// a write drives the data lines and pulses only write enable
	property p_ext_write;
		@(posedge i_mclk) disable iff (i_reset)
		(ext_take && i_write) |=> (o_port_write_en && !o_port_data_oe_n && !o_port_output_en);
	endproperty
	a_ext_write: assert property (p_ext_write) else $error("external write strobes wrong");
	// a read releases the data lines and raises only output enable
	property p_ext_read;
		@(posedge i_mclk) disable iff (i_reset)
		(ext_take && !i_write) |=> (o_port_output_en && o_port_data_oe_n && !o_port_write_en);
	endproperty
	a_ext_read: assert property (p_ext_read) else $error("external read strobes wrong");
	// the low address bits reach the pins unchanged
	property p_ext_addr;
		@(posedge i_mclk) disable iff (i_reset)
		(ext_take && !i_viewport_en) |=> (o_port_addr == $past(addr21) && o_port_addr_valid);
	endproperty
	a_ext_addr: assert property (p_ext_addr) else $error("external address wrong");
	// an acquiring read returns the previous owner with the bit set
	property p_token_read_data;
		@(posedge i_mclk) disable iff (i_reset)
		(int_take && hit_token && !i_write && avail_q) |=> (o_rdata == {1'b1, $past(owner_q), 28'h0});
	endproperty
	a_token_read_data: assert property (p_token_read_data) else $error("acquire read data wrong");
	// a seconds read returns the value standing at the take
	property p_secs_read;
		@(posedge i_mclk) disable iff (i_reset)
		(int_take && hit_secs && !i_write) |=> (o_ack && o_rdata == $past(secs_q));
	endproperty
	a_secs_read: assert property (p_secs_read) else $error("seconds read wrong");
	// one command reset per rising edge, never a held request
	property p_toc_pulse;
		@(posedge i_mclk) disable iff (i_reset)
		o_cmd_reset_req |=> !o_cmd_reset_req;
	endproperty
	a_toc_pulse: assert property (p_toc_pulse) else $error("command reset not a pulse");
	// viewport shows the selected set on the address pins
	property p_view;
		@(posedge i_mclk) disable iff (i_reset)
		i_viewport_en |=> (o_port_addr == {13'h0, $past(i_port_data)} && o_view_select == $past(i_port_data));
	endproperty
	a_view: assert property (p_view) else $error("viewport selection wrong");
	// a panel write loads the payload field and a full bit count
	property p_panel_start;
		@(posedge i_mclk) disable iff (i_reset)
		(int_take && i_write && hit_panel) |=> (pbits_q == 5'h14 && pshift_q == 20'($past(i_wdata) >> `PDSU_PANEL_LSB));
	endproperty
	a_panel_start: assert property (p_panel_start) else $error("panel load wrong");
endmodule

// File: pdsu_unit_test.sv
// self-checking testbench for the processor-dependent space unit
`timescale 1ns/1ps
module pdsu_unit_test;
	// ===========================================
	// signals
	localparam int unsigned SEC = 20; // shortened second
	logic clk, rst, req, wr, transfer_of_control_input, vp, ack, pvalid, poe_n, pwe, pre, pso, psc, creq;
	logic [31:0] addr, wdata, rdata;
	logic [2:0] mid, tid, ctgt;
	logic [20:0] paddr;
	logic [7:0] pdo, pdi, vsel, sel;
	logic [19:0] pbits;
	int num_errors = 0, cmp_count = 0, pcnt = 0, cyc = 0;
	pdsu_unit #(.SECOND_CYC(SEC), .PANEL_HALF_CYC(10)) i_pdsu_unit (.i_mclk(clk), .i_reset(rst),
		.i_req(req), .i_write(wr), .i_addr(addr), .i_wdata(wdata), .i_master_id(mid), .o_ack(ack),
		.o_rdata(rdata), .o_port_addr(paddr), .o_port_addr_valid(pvalid), .o_port_data(pdo),
		.o_port_data_oe_n(poe_n), .i_port_data(pdi), .o_port_write_en(pwe), .o_port_output_en(pre),
		.o_panel_serial_out(pso), .o_panel_shift_clock(psc), .i_transfer_of_control_input(transfer_of_control_input),
		.i_control_transfer_target_id(tid), .o_cmd_reset_req(creq), .o_cmd_reset_target(ctgt),
		.i_viewport_en(vp), .o_view_select(vsel));
	pdsu_port_model i_pdsu_port_model (.i_mclk(clk), .i_addr(paddr), .i_valid(pvalid), .i_data(pdo),
		.i_oe_n(poe_n), .i_we(pwe), .i_re(pre), .i_vp(vp), .i_sel(sel), .o_data(pdi));
	// ===========================================
	// clock, cycle count and panel capture
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	always @(posedge clk) cyc++;
	// panel data is stable at the clock fall
	always @(negedge psc) begin
		pbits = {pbits[18:0], pso};
		pcnt++;
	end
	// ===========================================
	// tasks
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			num_errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// one single-word access; lat counts rising edges up to the one that samples the answer
	task automatic acc(input logic w, input logic [31:0] a, input logic [31:0] d, input logic [2:0] id,
		output logic [31:0] rd, output int lat);
		logic got;
		got = 1'b0;
		lat = 0;
		rd = 32'hX;
		@(posedge clk);
		req <= 1'b1;
		wr <= w;
		addr <= a;
		wdata <= d;
		mid <= id;
		while (lat < 100 && !got) begin
			@(posedge clk);
			lat++;
			// values read here are those standing just before this edge
			if (ack === 1'b1) begin
				rd = rdata;
				got = 1'b1;
			end
		end
		req <= 1'b0; // released at the edge that sampled the answer
		if (!got) begin
			chk(32'h0, 32'h1); // no answer
		end
	endtask
	task automatic conclude();
		$display("errors %0d comparisons %0d", num_errors, cmp_count);
		if (num_errors == 0 && cmp_count > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	// watchdog sized well above the whole sequence
	initial begin
		#100000;
		num_errors++;
		conclude();
	end
	// ===========================================
	// test sequence
	initial begin
		logic [31:0] r, a, b;
		logic [31:0] xa [4];
		int lat, ca;
		xa = '{32'h10, 32'h15FFFF, 32'h180020, 32'h1FFFFE};
		{rst, req, wr, transfer_of_control_input, vp} = 5'b10000;
		addr = 32'h0;
		wdata = 32'h0;
		mid = 3'h0;
		tid = 3'h0;
		sel = 8'h00;
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		// token: acquire, owned read, release by write
		acc(1'b0, 32'h160004, 32'h0, 3'h5, r, lat); chk(r, 32'h80000000);
		chk(lat, 2); // internal answer one cycle after take
		acc(1'b0, 32'h160007, 32'h0, 3'h2, r, lat); chk(r, 32'h50000000);
		acc(1'b1, 32'h160005, 32'h0, 3'h2, r, lat);
		acc(1'b0, 32'h160006, 32'h0, 3'h3, r, lat); chk(r, 32'hD0000000);
		acc(1'b0, 32'h160004, 32'h0, 3'h1, r, lat); chk(r, 32'h30000000);
		// seconds counter across a second reset
		acc(1'b1, 32'h160000, 32'h12345678, 3'h0, r, lat);
		acc(1'b0, 32'h160000, 32'h0, 3'h0, a, lat); ca = cyc;
		chk(a - 32'h12345678 <= 32'h1, 1'b1);
		rst <= 1'b1;
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		repeat (100) @(posedge clk);
		acc(1'b0, 32'h160000, 32'h0, 3'h0, b, lat);
		// the prescaler restarts on reset, so a few ticks may be lost across it
		chk((b - a) + 32'h4 > (cyc - ca) / SEC && (b - a) < (cyc - ca) / SEC + 3, 1'b1);
		acc(1'b0, 32'h160004, 32'h0, 3'h4, r, lat); chk(r, 32'h80000000);
		// unused internal space and write-only panel register
		acc(1'b1, 32'h16000C, 32'hFFFFFFFF, 3'h0, r, lat);
		acc(1'b0, 32'h16000C, 32'h0, 3'h0, r, lat); chk(r, 32'h0);
		acc(1'b0, 32'h17FFFF, 32'h0, 3'h0, r, lat); chk(r, 32'h0);
		acc(1'b0, 32'h160008, 32'h0, 3'h0, r, lat); chk(r, 32'h0);
		// panel shift, msb first, clock parked low afterwards
		pcnt = 0;
		acc(1'b1, 32'hFFF60008, 32'hA5A5CABC, 3'h0, r, lat); // upper address bits ignored
		repeat (600) @(posedge clk);
		chk(pcnt, 20);
		chk(pbits, 20'hA5A5C);
		chk(psc, 1'b0);
		// external fast and slow windows, one low address and one at or near the top of each
		for (int k = 0; k < 4; k++) begin
			acc(1'b1, xa[k], 32'hC0 + k, 3'h0, r, lat);
		end
		for (int k = 0; k < 4; k++) begin
			acc(1'b0, xa[k], 32'h0, 3'h0, r, lat); chk(r[7:0], 8'hC0 + k);
			chk(lat, k < 2 ? 12 : 42);
		end
		// transfer of control gives one command reset pulse
		@(posedge clk);
		tid <= 3'h6;
		transfer_of_control_input <= 1'b1;
		lat = 0;
		repeat (6) begin
			@(negedge clk);
			if (creq === 1'b1) begin
				lat++;
				chk(ctgt, 3'h6);
			end
		end
		chk(lat, 1);
		@(posedge clk);
		transfer_of_control_input <= 1'b0;
		// viewport shows the jig's selection on the address pins
		vp <= 1'b1;
		sel <= 8'h5A;
		repeat (3) @(posedge clk);
		@(negedge clk);
		chk(vsel, 8'h5A);
		chk(paddr, 21'h5A);
		@(posedge clk);
		vp <= 1'b0;
		conclude();
	end
endmodule
